/* File: design/interval_timer_pkg.sv */
// constants, register map and carrier types for the clock prescaler and interval timer
// Summary of operation
// - eight-bit counter runs freely, halted in plain stop and while main is stopped on sub clock
// - counter steps on prescaler pulse, ratio 8..1024
// - wrap from max to zero sets irq flag
// - clear bit write zeroes counter, counting resumes
// - clear bit drops back after one cycle
// - low three control bits pick prescaler tap
// - shared address reads counter, writes control
// - stop with rc select keeps only timer and enabled sub clock alive
// - counter overflow drives watchdog time base
// - reset-enable bit picks watchdog or plain timer
// - mode bits zero and one pick system clock
// - sub clock selected, bit two stops main
// - after reset fastest prescaled clock is used
// - peripheral clock undivided or divided to 4096
// - stop gates peripheral clock, wake restores it
// - main oscillator enters through divide-by-two flop except at peripheral code zero
// - sub oscillator runs only while enabled
package interval_timer_pkg;

  // register offsets, byte addresses on the plain port
  localparam logic [7:0] OFS_SYSTEM_CLOCK_MODE = 8'hf1;
  localparam logic [7:0] OFS_COUNT_AND_CONTROL = 8'hf2;
  localparam logic [7:0] OFS_PERIPH_CLOCK_SEL = 8'hf3;
  localparam logic [7:0] OFS_PORT_SELECT_ONE = 8'hf9;

  // clock_control field positions
  localparam int CTL_TAP_LSB = 0;
  localparam int CTL_TAP_W = 3;
  localparam int CTL_CLEAR_BIT = 3;
  localparam int CTL_WDT_RESET_BIT = 4;
  localparam int CTL_RC_WDT_BIT = 5;

  // system_clock_mode field positions and select codes
  localparam int SCM_SEL_LSB = 0;
  localparam int SCM_MAIN_STOP_BIT = 2;
  localparam logic [1:0] SYSCLK_FASTEST = 2'h0;
  localparam logic [1:0] SYSCLK_DIV8 = 2'h1;

  // port_select_register_one field position
  localparam int PORT_SELECT_REGISTER_ONE_SUB_OSC_EN_BIT = 3;

  // widths and reset values
  localparam int COUNT_W = 8;
  localparam int PRESCALE_W = 11;
  localparam int PERIPH_SEL_W = 4;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [10:0] PRESCALE_RESET = 11'h000;
  localparam logic [2:0] TAP_RESET = 3'h0;
  localparam logic [2:0] SCM_RESET = 3'h0;
  localparam logic [7:0] PORT_SELECT_REGISTER_ONE_RESET = 8'h00;
  localparam logic [3:0] PERIPH_SEL_RESET = 4'h0;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  // division ratios against the oscillator
  localparam int TAP_RATIO_MIN = 8;
  localparam int TAP_RATIO_MAX = 1024;
  localparam logic [3:0] PERIPH_SEL_MAX = 4'hc;

  // power states
  typedef enum logic [1:0] {PWR_RUN, PWR_STOP, PWR_STOP_RC} power_type;

  // register port request from the cpu side
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  // oscillator run enables driven to the analog cells
  typedef struct packed {
    logic main_run;
    logic sub_run;
    logic rc_run;
  } osc_ctrl_type;

endpackage : interval_timer_pkg

/* File: design/clock_prescaler_interval_timer.sv */
// clock selection, prescaler and free-running interval timer
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
module clock_prescaler_interval_timer
  import interval_timer_pkg::*;
(
  input wire logic clk_sys, // system clock, 100 MHz
  input wire logic rst_n, // asynchronous reset, active low
  input wire reg_req_type reg_req, // register port request
  output logic [7:0] reg_rdata, // read data, one cycle after read strobe
  input wire logic main_osc_in, // main oscillator pin level
  input wire logic sub_osc_in, // sub oscillator pin level
  input wire logic rc_osc_in, // internal rc oscillator level
  input wire logic stop_request, // stop instruction executed, pulse
  input wire logic wake_request, // stop release event, pulse
  input wire logic irq_flag_clear, // cpu acknowledges the interrupt
  output logic interval_timer_irq_flag, // sticky overflow flag
  output logic wdt_count_pulse, // watchdog time base, one pulse per wrap
  output logic watchdog_reset_enable, // watchdog resets cpu when high
  output logic sys_clock_pulse, // selected system clock tick
  output logic periph_clock_pulse, // peripheral clock tick
  output osc_ctrl_type osc_ctrl, // oscillator run enables
  output power_type power_state // current power state
);

  // complete state of the block
  typedef struct packed {
    logic [1:0] main_sync; // main pin synchroniser
    logic main_prev; // last synchronised main level
    logic main_half; // divide-by-two flop
    logic [1:0] sub_sync; // sub pin synchroniser
    logic sub_prev; // last synchronised sub level
    logic [1:0] rc_sync; // rc pin synchroniser
    logic rc_prev; // last synchronised rc level
    logic [PRESCALE_W-1:0] prescale; // prescaler chain
    logic [COUNT_W-1:0] count; // interval counter
    logic [CTL_TAP_W-1:0] tap; // prescaler tap select
    logic count_clear; // self-clearing clear bit
    logic wdt_reset_en; // watchdog reset enable
    logic rc_wdt_sel; // rc watchdog select
    logic [2:0] scm; // system clock mode
    logic [7:0] port_select_register_one; // port select register one
    logic [PERIPH_SEL_W-1:0] periph_sel; // peripheral divide select
    power_type power; // power state
    logic irq_flag; // overflow flag
    logic wdt_tick; // watchdog time base pulse
    logic sys_pulse; // system clock pulse
    logic periph_pulse; // peripheral clock pulse
    logic [7:0] rdata; // read data
    osc_ctrl_type osc; // oscillator enables
  } state_type;

  // one struct holds every flop, so reset and the register copy stay in step;
  // the price is that each field needs its own constant in the reset branch
  // below, because the reset branch may only load constants
  state_type s; // registered state
  state_type next_s; // next state

  // combinational helpers shared with the assertions
  logic main_edge; // synchronised main rising edge
  logic main_tick; // main clock after divide-by-two
  logic sub_edge; // synchronised sub rising edge
  logic rc_edge; // synchronised rc rising edge
  logic count_step; // interval counter step
  logic overflow; // counter wrap this cycle
  logic ctl_write; // write to shared address
  logic [7:0] read_mux; // read value before register

  // true when prescale bits 0..n are all ones, so the next tick carries past bit n
  function automatic logic carry_out(input logic [PRESCALE_W-1:0] pre, input int n);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < PRESCALE_W; i++) begin
      if (i <= n) begin
        ok = ok & pre[i];
      end
    end
    return ok;
  endfunction

  // next state
  always_comb begin
    next_s = s;

    // synchronisers: first stage feeds only the second
    next_s.main_sync = {s.main_sync[0], main_osc_in};
    next_s.sub_sync = {s.sub_sync[0], sub_osc_in};
    next_s.rc_sync = {s.rc_sync[0], rc_osc_in};
    next_s.main_prev = s.main_sync[1];
    next_s.sub_prev = s.sub_sync[1];
    next_s.rc_prev = s.rc_sync[1];

    // edges of the oscillators, only while they are allowed to run
    main_edge = s.main_sync[1] & ~s.main_prev & s.osc.main_run;
    sub_edge = s.sub_sync[1] & ~s.sub_prev & s.osc.sub_run;
    rc_edge = s.rc_sync[1] & ~s.rc_prev & s.osc.rc_run;

    // divide-by-two: duty cycle of the pin never reaches the tree
    main_tick = main_edge & s.main_half;
    if (main_edge) begin
      next_s.main_half = ~s.main_half;
    end

    // prescaler runs on the halved main clock, halted in any stop
    if (main_tick && s.power == PWR_RUN) begin
      next_s.prescale = s.prescale + 1'b1;
    end

    // counter step: tap n divides the oscillator by 8 << n
    count_step = 1'b0;
    unique case (s.power)
      PWR_RUN: count_step = main_tick & carry_out(s.prescale, int'(s.tap) + 1);
      PWR_STOP_RC: count_step = rc_edge;
      PWR_STOP: count_step = 1'b0;
      default: count_step = 1'b0; // illegal code never steps
    endcase

    // clear has priority over a step in the same cycle
    overflow = count_step & ~s.count_clear & (s.count == COUNT_MAX);
    if (s.count_clear) begin
      next_s.count = COUNT_RESET;
    end else if (count_step) begin
      next_s.count = s.count + 1'b1;
    end

    // wrap raises the flag and the watchdog time base; set wins over clear
    next_s.wdt_tick = overflow;
    if (overflow) begin
      next_s.irq_flag = 1'b1;
    end else if (irq_flag_clear) begin
      next_s.irq_flag = 1'b0;
    end

    // clear bit lives exactly one machine cycle
    next_s.count_clear = 1'b0;

    // register writes
    ctl_write = reg_req.wr & (reg_req.addr == OFS_COUNT_AND_CONTROL);
    if (ctl_write) begin
      // a write here never touches the counter value directly
      next_s.tap = reg_req.wdata[CTL_TAP_LSB +: CTL_TAP_W];
      next_s.count_clear = reg_req.wdata[CTL_CLEAR_BIT];
      next_s.wdt_reset_en = reg_req.wdata[CTL_WDT_RESET_BIT];
      next_s.rc_wdt_sel = reg_req.wdata[CTL_RC_WDT_BIT];
    end
    if (reg_req.wr && reg_req.addr == OFS_SYSTEM_CLOCK_MODE) begin
      next_s.scm = reg_req.wdata[2:0];
    end
    if (reg_req.wr && reg_req.addr == OFS_PERIPH_CLOCK_SEL) begin
      next_s.periph_sel = reg_req.wdata[PERIPH_SEL_W-1:0];
    end
    if (reg_req.wr && reg_req.addr == OFS_PORT_SELECT_ONE) begin
      next_s.port_select_register_one = reg_req.wdata;
    end

    // read path: shared address answers with the counter
    // the control bits at that address cannot be read back, so software
    // must keep its own copy of the tap and mode bits
    read_mux = RDATA_IDLE;
    unique case (reg_req.addr)
      OFS_COUNT_AND_CONTROL: read_mux = s.count;
      OFS_SYSTEM_CLOCK_MODE: read_mux = {5'h00, s.scm};
      OFS_PERIPH_CLOCK_SEL: read_mux = {4'h0, s.periph_sel};
      OFS_PORT_SELECT_ONE: read_mux = s.port_select_register_one;
      default: read_mux = RDATA_IDLE; // unmapped reads as zero
    endcase
    next_s.rdata = reg_req.rd ? read_mux : RDATA_IDLE;

    // power sequencing: rc select at the stop decides the mode
    // the select bit is only looked at on the stop pulse, so changing it
    // while already stopped has no effect until the next stop
    // wake always lands in run, whichever stop was in force
    unique case (s.power)
      PWR_RUN: begin
        if (stop_request) begin
          next_s.power = s.rc_wdt_sel ? PWR_STOP_RC : PWR_STOP;
        end
      end
      PWR_STOP, PWR_STOP_RC: begin
        if (wake_request) begin
          next_s.power = PWR_RUN;
        end
      end
      default: next_s.power = PWR_RUN; // illegal code recovers to run
    endcase

    // rc and main enables follow the next power state, sub enable follows its port select bit
    next_s.osc.rc_run = (next_s.power == PWR_STOP_RC);
    next_s.osc.sub_run = next_s.port_select_register_one[PORT_SELECT_REGISTER_ONE_SUB_OSC_EN_BIT];
    next_s.osc.main_run = (next_s.power == PWR_RUN) &&
      !(next_s.scm[1] && next_s.scm[SCM_MAIN_STOP_BIT]);

    // system clock selection; sub codes share the top bit
    unique case (s.scm[1:0])
      SYSCLK_FASTEST: next_s.sys_pulse = main_tick;
      SYSCLK_DIV8: next_s.sys_pulse = main_tick & carry_out(s.prescale, 1);
      default: next_s.sys_pulse = sub_edge;
    endcase

    // peripheral clock, gated off whenever a stop is in force
    if (s.power != PWR_RUN) begin
      next_s.periph_pulse = 1'b0;
    end else if (s.periph_sel == 4'h0) begin
      next_s.periph_pulse = main_edge;
    end else if (s.periph_sel == 4'h1) begin
      next_s.periph_pulse = main_tick;
    end else if (s.periph_sel >= PERIPH_SEL_MAX) begin
      // codes above the largest ratio saturate at divide-by-4096
      next_s.periph_pulse = main_tick & carry_out(s.prescale, int'(PERIPH_SEL_MAX) - 2);
    end else begin
      next_s.periph_pulse = main_tick & carry_out(s.prescale, int'(s.periph_sel) - 2);
    end
  end

  // state register; constants only under reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s.main_sync <= 2'h0;
      s.main_prev <= 1'b0;
      s.main_half <= 1'b0;
      s.sub_sync <= 2'h0;
      s.sub_prev <= 1'b0;
      s.rc_sync <= 2'h0;
      s.rc_prev <= 1'b0;
      s.prescale <= PRESCALE_RESET;
      s.count <= COUNT_RESET;
      s.tap <= TAP_RESET;
      s.count_clear <= 1'b0;
      s.wdt_reset_en <= 1'b0;
      s.rc_wdt_sel <= 1'b0;
      s.scm <= SCM_RESET;
      s.port_select_register_one <= PORT_SELECT_REGISTER_ONE_RESET;
      s.periph_sel <= PERIPH_SEL_RESET;
      s.power <= PWR_RUN;
      s.irq_flag <= 1'b0;
      s.wdt_tick <= 1'b0;
      s.sys_pulse <= 1'b0;
      s.periph_pulse <= 1'b0;
      s.rdata <= RDATA_IDLE;
      s.osc <= '{main_run: 1'b1, sub_run: 1'b0, rc_run: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign reg_rdata = s.rdata;
  assign interval_timer_irq_flag = s.irq_flag;
  assign wdt_count_pulse = s.wdt_tick;
  assign watchdog_reset_enable = s.wdt_reset_en;
  assign sys_clock_pulse = s.sys_pulse;
  assign periph_clock_pulse = s.periph_pulse;
  assign osc_ctrl = s.osc;
  assign power_state = s.power;

  // checks, all on the system clock
  // every check watches flops, helpers or cpu-side inputs of this block, never the oscillator pins;
  // oscillator pins are asynchronous and only their synchronised
  // copies are meaningful here
  // a reset in mid-run disables all checks until it is released
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // a clear write takes two cycles to land on the counter
  sequence clear_written;
    reg_req.wr && reg_req.addr == OFS_COUNT_AND_CONTROL && reg_req.wdata[CTL_CLEAR_BIT];
  endsequence
  sequence clear_lands;
    s.count_clear ##1 (s.count == COUNT_RESET && !s.count_clear);
  endsequence

  AST_CLEAR_SEQUENCE: assert property (clear_written |=> clear_lands)
    else $error("counter clear did not zero the counter in two cycles");

  AST_CLEAR_SELF_DROPS: assert property (s.count_clear |=> !s.count_clear)
    else $error("clear bit stayed high beyond one cycle");

  AST_COUNT_STEPS: assert property (count_step && !s.count_clear
    |=> s.count == $past(s.count) + 8'h01)
    else $error("counter did not advance on its count pulse");

  AST_COUNT_HOLDS: assert property (!count_step && !s.count_clear |=> $stable(s.count))
    else $error("counter moved without a count pulse");

  AST_WRAP_FLAGS: assert property (count_step && !s.count_clear && s.count == COUNT_MAX
    |=> s.irq_flag && s.wdt_tick && s.count == COUNT_RESET)
    else $error("wrap did not raise the flag and watchdog pulse");

  AST_WDT_ONLY_ON_WRAP: assert property (s.wdt_tick |-> $past(s.count) == COUNT_MAX)
    else $error("watchdog time base pulsed without a wrap");

  AST_SHARED_READ: assert property (reg_req.rd && reg_req.addr == OFS_COUNT_AND_CONTROL
    |=> reg_rdata == $past(s.count))
    else $error("shared address did not read the counter");

  AST_RC_STOP: assert property (s.power == PWR_RUN && stop_request && s.rc_wdt_sel
    |=> s.power == PWR_STOP_RC && s.osc.rc_run && !s.osc.main_run)
    else $error("stop with rc select did not enter rc watchdog mode");

  AST_PERIPH_GATED: assert property (s.power != PWR_RUN ##1 s.power != PWR_RUN
    |-> !s.periph_pulse)
    else $error("peripheral clock ran during stop");

  AST_MAIN_STOP_ON_SUB: assert property (s.scm[1] && s.scm[SCM_MAIN_STOP_BIT]
    |-> !s.osc.main_run)
    else $error("main oscillator ran while stopped on sub clock");

  AST_SUB_ENABLE: assert property (!s.port_select_register_one[PORT_SELECT_REGISTER_ONE_SUB_OSC_EN_BIT] |-> !s.osc.sub_run)
    else $error("sub oscillator ran while disabled");

  AST_HALF_DIVIDE: assert property (main_tick |-> s.main_half ##1 !s.main_half)
    else $error("main tick not on the divide-by-two phase");

  // stop entry and the way out, one cycle each
  sequence plain_stop_asked;
    s.power == PWR_RUN && stop_request && !s.rc_wdt_sel;
  endsequence
  sequence plain_stop_entered;
    s.power == PWR_STOP && !s.osc.rc_run && !s.osc.main_run;
  endsequence
  sequence wake_asked;
    s.power != PWR_RUN && wake_request;
  endsequence

  // plain stop halts every oscillator the timer could use
  AST_PLAIN_STOP: assert property (plain_stop_asked |=> plain_stop_entered)
    else $error("stop without rc select did not enter plain stop");

  // any stop is left on the wake pulse
  AST_WAKE_RUNS: assert property (wake_asked |=> s.power == PWR_RUN)
    else $error("wake pulse did not return to run");

  // plain stop freezes the counter: no step may reach it
  AST_STOP_NO_STEP: assert property (s.power == PWR_STOP |-> !count_step)
    else $error("counter stepped during plain stop");

  // prescaler only moves while running, so a stop loses no phase
  AST_PRESCALE_HALTS: assert property (s.power != PWR_RUN |=> $stable(s.prescale))
    else $error("prescaler moved during stop");

  // set wins when a wrap and an acknowledge meet
  AST_FLAG_SET_WINS: assert property (overflow && irq_flag_clear |=> s.irq_flag)
    else $error("acknowledge beat a wrap in the same cycle");

  // acknowledge without a wrap drops the flag
  AST_FLAG_CLEARS: assert property (!overflow && irq_flag_clear |=> !s.irq_flag)
    else $error("flag survived an acknowledge");

  // flag is sticky and only a wrap raises it
  AST_FLAG_ONLY_ON_WRAP: assert property (!s.irq_flag ##1 s.irq_flag |-> s.wdt_tick)
    else $error("flag rose without a wrap");

  // read data stands one cycle only, zero between reads
  AST_RDATA_IDLE: assert property (!reg_req.rd |=> reg_rdata == RDATA_IDLE)
    else $error("read data stood without a read strobe");

  // sub oscillator follows its enable both ways
  AST_SUB_ENABLE_ON: assert property (s.port_select_register_one[PORT_SELECT_REGISTER_ONE_SUB_OSC_EN_BIT] |-> s.osc.sub_run)
    else $error("sub oscillator stopped while enabled");

  // after reset the fastest tap drives the system clock
  AST_FASTEST_CLOCK: assert property (s.scm[1:0] == SYSCLK_FASTEST && main_tick
    |=> s.sys_pulse)
    else $error("fastest clock did not reach the system clock");

  // every wrap reaches the watchdog time base
  AST_WRAP_TIMEBASE: assert property (overflow |=> wdt_count_pulse)
    else $error("wrap did not pulse the watchdog time base");

  // peripheral code zero passes every main edge while running
  AST_PERIPH_UNDIVIDED: assert property (s.power == PWR_RUN && s.periph_sel == 4'h0
    && main_edge |=> s.periph_pulse)
    else $error("undivided peripheral clock missed a main edge");

endmodule // clock_prescaler_interval_timer

/* File: sim/clock_prescaler_interval_timer_test.sv */
// self-checking bench for the clock prescaler and interval timer
`timescale 1ns/1ns
module clock_prescaler_interval_timer_test import interval_timer_pkg::*;;
  logic clk_sys; // 100 MHz system clock
  logic rst_n; // active low reset
  reg_req_type reg_req; // register port request
  logic [7:0] reg_rdata; // read data
  logic main_osc_in; // main oscillator, half the system rate
  logic sub_osc_in; // sub oscillator level
  logic rc_osc_in; // rc oscillator, one rise per 8 cycles
  logic stop_request; // stop pulse
  logic wake_request; // wake pulse
  logic irq_flag_clear; // flag acknowledge
  logic interval_timer_irq_flag; // sticky wrap flag
  logic wdt_count_pulse; // watchdog time base
  logic watchdog_reset_enable; // watchdog mode level
  logic sys_clock_pulse; // system clock tick
  logic periph_clock_pulse; // peripheral clock tick
  osc_ctrl_type osc_ctrl; // oscillator enables
  power_type power_state; // power state
  logic [2:0] rc_div; // divider for the slow oscillators
  logic [7:0] a; // first read value
  logic [7:0] b; // second read value
  int err_total; // mismatches
  int n_compared; // comparisons
  int sys_cnt; // system ticks seen
  int per_cnt; // peripheral ticks seen
  int wdt_cnt; // watchdog ticks seen
  int c0; // tick snapshot
  int n; // bounded wait counter

  clock_prescaler_interval_timer clock_prescaler_interval_timer_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .main_osc_in(main_osc_in), .sub_osc_in(sub_osc_in), .rc_osc_in(rc_osc_in),
    .stop_request(stop_request), .wake_request(wake_request),
    .irq_flag_clear(irq_flag_clear), .interval_timer_irq_flag(interval_timer_irq_flag),
    .wdt_count_pulse(wdt_count_pulse), .watchdog_reset_enable(watchdog_reset_enable),
    .sys_clock_pulse(sys_clock_pulse), .periph_clock_pulse(periph_clock_pulse),
    .osc_ctrl(osc_ctrl), .power_state(power_state)
  );

  // clock generator
  always #5 clk_sys = ~clk_sys;

  // oscillators locked to clk_sys so every rate window counts exactly
  always @(posedge clk_sys) begin
    main_osc_in <= ~main_osc_in;
    rc_div <= rc_div + 3'h1;
    rc_osc_in <= rc_div[2];
    sub_osc_in <= rc_div[1];
  end

  // tick counters, compared as differences over whole periods
  always @(posedge clk_sys) begin
    if (sys_clock_pulse === 1'b1) sys_cnt <= sys_cnt + 1;
    if (periph_clock_pulse === 1'b1) per_cnt <= per_cnt + 1;
    if (wdt_count_pulse === 1'b1) wdt_cnt <= wdt_cnt + 1;
  end

  // one comparison, counted
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // single-cycle write strobe, one idle cycle after
  task automatic reg_write(input logic [7:0] adr, input logic [7:0] d);
    reg_req.addr <= adr;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge clk_sys);
    reg_req.wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  // read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] adr, output logic [7:0] d);
    reg_req.addr <= adr;
    reg_req.rd <= 1'b1;
    @(posedge clk_sys);
    reg_req.rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  // one-cycle pulse on stop or wake, then let the state settle
  task automatic power_pulse(input logic wake);
    if (wake) wake_request <= 1'b1;
    else stop_request <= 1'b1;
    @(posedge clk_sys);
    wake_request <= 1'b0;
    stop_request <= 1'b0;
    cycles(2);
  endtask

  // verdict and end of run
  task automatic test_done;
    if (err_total == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog, about two and a half times the expected run length
  initial begin
    repeat (50000) @(posedge clk_sys);
    err_total++;
    test_done();
  end

  // main sequence
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    reg_req = '0;
    main_osc_in = 1'b0;
    sub_osc_in = 1'b0;
    rc_osc_in = 1'b0;
    rc_div = 3'h0;
    stop_request = 1'b0;
    wake_request = 1'b0;
    irq_flag_clear = 1'b0;
    {err_total, n_compared, sys_cnt, per_cnt, wdt_cnt} = '0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    // reset state
    reg_read(OFS_COUNT_AND_CONTROL, a);
    check("count_reset", a, 16'h0000);
    check("power_reset", power_state, PWR_RUN);
    reg_read(OFS_PERIPH_CLOCK_SEL, a);
    check("periph_sel_reset", a, 16'h0000);
    reg_read(8'h10, a);
    check("unmapped_read", a, 16'h0000);
    // fastest system clock until software picks another
    c0 = sys_cnt;
    cycles(256);
    check("sys_fastest", 16'(sys_cnt - c0), 16'h0040);
    reg_write(OFS_SYSTEM_CLOCK_MODE, 8'h01);
    cycles(32);
    c0 = sys_cnt;
    cycles(256);
    check("sys_div8", 16'(sys_cnt - c0), 16'h0010);
    // main stop bit only bites with the sub clock selected
    reg_write(OFS_SYSTEM_CLOCK_MODE, 8'h06);
    cycles(2);
    check("main_stopped", osc_ctrl.main_run, 16'h0000);
    reg_read(OFS_SYSTEM_CLOCK_MODE, a);
    check("scm_readback", a, 16'h0006);
    reg_write(OFS_SYSTEM_CLOCK_MODE, 8'h02);
    cycles(2);
    check("main_running", osc_ctrl.main_run, 16'h0001);
    reg_write(OFS_SYSTEM_CLOCK_MODE, 8'h00);
    // sub oscillator enable
    reg_write(OFS_PORT_SELECT_ONE, 8'h08);
    cycles(2);
    check("sub_on", osc_ctrl.sub_run, 16'h0001);
    reg_write(OFS_SYSTEM_CLOCK_MODE, 8'h02);
    cycles(32);
    c0 = sys_cnt;
    cycles(256);
    check("sys_sub", 16'(sys_cnt - c0), 16'h0040);
    reg_write(OFS_SYSTEM_CLOCK_MODE, 8'h00);
    reg_write(OFS_PORT_SELECT_ONE, 8'h00);
    cycles(2);
    check("sub_off", osc_ctrl.sub_run, 16'h0000);
    // every prescaler tap: two steps per two step periods
    for (int k = 0; k < 8; k++) begin
      reg_write(OFS_COUNT_AND_CONTROL, 8'(k));
      cycles(16 << k);
      reg_read(OFS_COUNT_AND_CONTROL, a);
      cycles((32 << k) - 2);
      reg_read(OFS_COUNT_AND_CONTROL, b);
      check("tap_rate", 8'(b - a), 16'h0002);
    end
    // clear, then counting must resume at the tap 0 rate
    reg_write(OFS_COUNT_AND_CONTROL, 8'h08);
    reg_read(OFS_COUNT_AND_CONTROL, a);
    check("cleared", a, 16'h0000);
    cycles(30);
    reg_read(OFS_COUNT_AND_CONTROL, b);
    check("resumed", 8'(b - a), 16'h0002);
    // full wrap from a clear sets the flag and one time-base tick
    irq_flag_clear <= 1'b1;
    reg_write(OFS_COUNT_AND_CONTROL, 8'h08);
    irq_flag_clear <= 1'b0;
    @(posedge clk_sys);
    check("flag_cleared", interval_timer_irq_flag, 16'h0000);
    c0 = wdt_cnt;
    n = 0;
    while (interval_timer_irq_flag !== 1'b1 && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    reg_read(OFS_COUNT_AND_CONTROL, a);
    check("wrap_value", a, 16'h0000);
    check("wrap_time", 16'(n >= 4000 && n < 4200), 16'h0001);
    check("wdt_ticks", 16'(wdt_cnt - c0), 16'h0001);
    check("flag_sticky", interval_timer_irq_flag, 16'h0001);
    // watchdog or plain timer mode bit
    reg_write(OFS_COUNT_AND_CONTROL, 8'h10);
    cycles(2);
    check("wdt_enable", watchdog_reset_enable, 16'h0001);
    reg_write(OFS_COUNT_AND_CONTROL, 8'h00);
    cycles(2);
    check("wdt_disable", watchdog_reset_enable, 16'h0000);
    // peripheral clock divisions
    for (int k = 0; k < 4; k++) begin
      reg_write(OFS_PERIPH_CLOCK_SEL, 8'(k));
      cycles(32);
      c0 = per_cnt;
      cycles(256);
      check("periph_rate", 16'(per_cnt - c0), 16'(128 >> k));
    end
    reg_write(OFS_PERIPH_CLOCK_SEL, 8'h00);
    // plain stop gates the peripheral clock and holds the counter
    power_pulse(1'b0);
    check("stopped", power_state, PWR_STOP);
    c0 = per_cnt;
    reg_read(OFS_COUNT_AND_CONTROL, a);
    cycles(254);
    reg_read(OFS_COUNT_AND_CONTROL, b);
    check("periph_gated", 16'(per_cnt - c0), 16'h0000);
    check("count_held", 8'(b - a), 16'h0000);
    power_pulse(1'b1);
    check("woken", power_state, PWR_RUN);
    c0 = per_cnt;
    cycles(256);
    check("periph_back", 16'(per_cnt - c0), 16'h0080);
    // stop after the rc select bit keeps the timer on the rc clock
    reg_write(OFS_COUNT_AND_CONTROL, 8'h20);
    power_pulse(1'b0);
    check("rc_stop", power_state, PWR_STOP_RC);
    check("rc_run_on", osc_ctrl.rc_run, 16'h0001);
    reg_read(OFS_COUNT_AND_CONTROL, a);
    cycles(78);
    reg_read(OFS_COUNT_AND_CONTROL, b);
    check("rc_rate", 8'(b - a), 16'h000a);
    power_pulse(1'b1);
    check("rc_run_off", osc_ctrl.rc_run, 16'h0000);
    reg_write(OFS_COUNT_AND_CONTROL, 8'h00);
    test_done();
  end
endmodule // clock_prescaler_interval_timer_test
